// File: core/isr_readout.sv
// Row and column selection and pixel streaming of the sensor readout.
`timescale 1ns/100ps
`default_nettype none
`include "isr_params.svh"
module isr_readout
    import isr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic row_sync,
    input wire logic row_clk,
    input wire logic col_sync,
    input wire logic col_clk,
    input wire logic cfg_load,
    input wire logic [`ISR_START_W-1:0] cfg_row_start,
    input wire logic [`ISR_START_W-1:0] cfg_col_start,
    input wire logic cfg_row_dir,
    input wire logic cfg_col_dir,
    input wire logic cfg_dual_out,
    input wire logic [`ISR_PIX_W-1:0] array_pix_a,
    input wire logic [`ISR_PIX_W-1:0] array_pix_b,
    output logic [`ISR_ADDR_W-1:0] row_sel_addr,
    output logic [`ISR_ADDR_W-1:0] col_sel_addr,
    output logic line_active,
    output logic frame_end,
    output logic overflow,
    output logic link_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [`ISR_PIX_W-1:0] out_pix1,
    output logic [`ISR_PIX_W-1:0] out_pix2,
    output logic out_pix2_valid
);
    // ----------------------------------------
    // Functions.
    // ----------------------------------------
    function automatic logic [`ISR_ADDR_W-1:0] start_addr(input logic [`ISR_START_W-1:0] s);
        start_addr = {s, 1'b0};
    endfunction

    function automatic logic [`ISR_ADDR_W-1:0] step_addr(input logic [`ISR_ADDR_W-1:0] a,
                                                      input logic dir,
                                                      input logic [`ISR_ADDR_W-1:0] n);
        step_addr = dir ? a - n : a + n;
    endfunction

    // ----------------------------------------
    // Pin synchronisation and edge detection.
    // ----------------------------------------
    logic [`ISR_SYNC_W-1:0] pins;
    logic s_row_sync;
    logic s_row_clk;
    logic s_col_sync;
    logic s_col_clk;
    logic row_rise;
    logic row_sync_rise;
    logic col_rise;
    logic col_fall;

    isr_sync #(
        .W(`ISR_SYNC_W)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .pin_in({col_clk, col_sync, row_clk, row_sync}),
        .pin_sync(pins)
    );

    isr_state_t st_reg;
    isr_state_t st_next;

    assign s_row_sync = pins[0];
    assign s_row_clk = pins[1];
    assign s_col_sync = pins[2];
    assign s_col_clk = pins[3];
    assign row_rise = s_row_clk & ~st_reg.row_clk_d;
    assign row_sync_rise = s_row_sync & ~st_reg.row_sync_d;
    assign col_rise = s_col_clk & ~st_reg.col_clk_d;
    assign col_fall = ~s_col_clk & st_reg.col_clk_d;

    // ----------------------------------------
    // Pixel FIFO.
    // ----------------------------------------
    logic push_valid;
    logic push_ready;
    logic push_two;
    logic [`ISR_PIX_W-1:0] push_p1;
    logic [`ISR_PIX_W-1:0] push_p2;
    logic [`ISR_FIFO_W-1:0] pop_data;

    isr_fifo #(
        .W(`ISR_FIFO_W),
        .DEPTH(`ISR_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data({push_two, push_p2, push_p1}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(pop_data)
    );

    assign out_pix1 = pop_data[`ISR_PIX_W-1:0];
    assign out_pix2 = pop_data[2*`ISR_PIX_W-1:`ISR_PIX_W];
    assign out_pix2_valid = pop_data[2*`ISR_PIX_W];
    assign link_ready = push_ready;

    // ----------------------------------------
    // Next state.
    // ----------------------------------------
    logic first_edge;

    always_comb begin
        st_next = st_reg;
        push_valid = 1'b0;
        push_two = 1'b0;
        push_p1 = `ISR_PIX_ZERO;
        push_p2 = `ISR_PIX_ZERO;
        first_edge = 1'b0;
        st_next.row_clk_d = s_row_clk;
        st_next.col_clk_d = s_col_clk;
        st_next.row_sync_d = s_row_sync;
        st_next.frame_end = 1'b0;
        st_next.first_pend = 1'b0;

        if (cfg_load) begin
            st_next.row_start = cfg_row_start; // RQ2
            st_next.col_start = cfg_col_start; // RQ2
            st_next.row_dir = cfg_row_dir;
            st_next.col_dir = cfg_col_dir;
            st_next.dual_out = cfg_dual_out;
        end

        if (row_sync_rise || (s_row_sync && row_rise)) begin
            st_next.row_addr = start_addr(st_reg.row_start); // RQ1 RQ3 RQ16
            st_next.line = ISR_LINE_IDLE;
            st_next.overflow = 1'b0;
        end else if (row_rise) begin
            st_next.line = ISR_LINE_IDLE; // RQ20
            if (st_reg.row_addr == (st_reg.row_dir ? `ISR_ADDR_ZERO : `ISR_ADDR_LAST)) begin
                st_next.frame_end = 1'b1;
            end else begin
                st_next.row_addr = step_addr(st_reg.row_addr, st_reg.row_dir, `ISR_STEP_ONE); // RQ15
            end
        end else if (s_col_sync && col_rise) begin
            st_next.col_addr = start_addr(st_reg.col_start); // RQ1 RQ3
            st_next.line = ISR_LINE_RUN; // RQ21
            st_next.first_pend = 1'b1;
        end else if (st_reg.line == ISR_LINE_RUN) begin
            first_edge = st_reg.first_pend | col_rise;
            if (first_edge) begin
                push_valid = 1'b1; // RQ19
                push_p1 = array_pix_a;
                if (st_reg.dual_out) begin
                    push_two = 1'b1;
                    push_p2 = array_pix_b;
                    st_next.col_addr = step_addr(st_reg.col_addr, st_reg.col_dir, `ISR_STEP_PAIR);
                end
            end else if (col_fall && !st_reg.dual_out) begin
                push_valid = 1'b1; // RQ19
                push_p1 = array_pix_b;
                st_next.col_addr = step_addr(st_reg.col_addr, st_reg.col_dir, `ISR_STEP_PAIR);
            end
            if (push_valid && !push_ready) begin
                st_next.overflow = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // State register.
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '{
                row_start: `ISR_START_ZERO, // RQ23
                col_start: `ISR_START_ZERO,
                row_dir: 1'b0,
                col_dir: 1'b0,
                dual_out: 1'b0,
                row_addr: `ISR_ADDR_ZERO,
                col_addr: `ISR_ADDR_ZERO,
                line: ISR_LINE_IDLE,
                first_pend: 1'b0,
                row_clk_d: 1'b0,
                col_clk_d: 1'b0,
                row_sync_d: 1'b0,
                frame_end: 1'b0,
                overflow: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign row_sel_addr = st_reg.row_addr;
    assign col_sel_addr = st_reg.col_addr;
    assign line_active = (st_reg.line == ISR_LINE_RUN);
    assign frame_end = st_reg.frame_end;
    assign overflow = st_reg.overflow;

    // ----------------------------------------
    // Assertions.
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_col_load;
        s_col_sync && col_rise && !row_rise && !row_sync_rise;
    endsequence

    property p_col_even;
        s_col_load |=> (col_sel_addr[0] == 1'b0) && line_active;
    endproperty
    a_col_even: assert property (p_col_even) else $error("column start not even"); // RQ1

    property p_start_hold;
        cfg_load |=> (st_reg.row_start == $past(cfg_row_start)) && (st_reg.col_start == $past(cfg_col_start));
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start value not held"); // RQ2

    property p_col_load;
        s_col_load ##0 (!cfg_load) |=> col_sel_addr == {$past(st_reg.col_start), 1'b0};
    endproperty
    a_col_load: assert property (p_col_load) else $error("column start not loaded"); // RQ3

    property p_row_step;
        (row_rise && !s_row_sync && !row_sync_rise && !st_reg.row_dir && row_sel_addr != `ISR_ADDR_LAST)
            |=> row_sel_addr == $past(row_sel_addr) + `ISR_STEP_ONE;
    endproperty
    a_row_step: assert property (p_row_step) else $error("row did not advance"); // RQ15

    property p_row_sync;
        row_sync_rise |=> (row_sel_addr == {$past(st_reg.row_start), 1'b0}) && !line_active;
    endproperty
    a_row_sync: assert property (p_row_sync) else $error("row sync did not reload"); // RQ16

    property p_single_pair;
        s_col_load ##0 (!st_reg.dual_out && !cfg_load) |=> push_valid && !push_two;
    endproperty
    a_single_pair: assert property (p_single_pair) else $error("single output push wrong"); // RQ19

    property p_idle_quiet;
        (st_reg.line == ISR_LINE_IDLE) |-> !push_valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pixel pushed outside a line"); // RQ21

    property p_reset_origin;
        $fell(reset) |-> (row_sel_addr == `ISR_ADDR_ZERO) && (col_sel_addr == `ISR_ADDR_ZERO) && !st_reg.dual_out;
    endproperty
    a_reset_origin: assert property (@(posedge clock) p_reset_origin) else $error("reset origin wrong"); // RQ23

    sequence s_row_tick;
        row_rise && !s_row_sync;
    endsequence

    sequence s_fall_push;
        line_active && col_fall && !st_reg.dual_out && !st_reg.first_pend && !row_rise && !s_row_sync;
    endsequence

    property p_row_even;
        row_sync_rise |=> (row_sel_addr[0] == 1'b0);
    endproperty
    a_row_even: assert property (p_row_even) else $error("row start not even"); // RQ1

    property p_sync_clk;
        (s_row_sync && row_rise) |=> (row_sel_addr == {$past(st_reg.row_start), 1'b0}) && !line_active;
    endproperty
    a_sync_clk: assert property (p_sync_clk) else $error("row start not loaded on row clock"); // RQ3

    property p_row_back;
        s_row_tick ##0 (st_reg.row_dir && (row_sel_addr != `ISR_ADDR_ZERO))
            |=> row_sel_addr == $past(row_sel_addr) - `ISR_STEP_ONE;
    endproperty
    a_row_back: assert property (p_row_back) else $error("row did not step back"); // RQ15

    property p_row_last;
        s_row_tick ##0 (!st_reg.row_dir && (row_sel_addr == `ISR_ADDR_LAST))
            |=> frame_end && (row_sel_addr == `ISR_ADDR_LAST);
    endproperty
    a_row_last: assert property (p_row_last) else $error("last row handled wrong"); // RQ15

    property p_dual_pair;
        s_col_load ##0 (st_reg.dual_out && !cfg_load) |=> push_valid && push_two;
    endproperty
    a_dual_pair: assert property (p_dual_pair) else $error("dual output push wrong"); // RQ19

    property p_single_fall;
        s_fall_push |-> push_valid && !push_two && (push_p1 == array_pix_b);
    endproperty
    a_single_fall: assert property (p_single_fall) else $error("second pixel not pushed on fall"); // RQ19

    property p_first_pix;
        s_col_load ##1 (!row_rise && !s_row_sync) |-> push_valid && (push_p1 == array_pix_a);
    endproperty
    a_first_pix: assert property (p_first_pix) else $error("first pixel not pushed"); // RQ21

    property p_col_idle;
        (!line_active && !(s_col_sync && col_rise)) |=> $stable(col_sel_addr);
    endproperty
    a_col_idle: assert property (p_col_idle) else $error("column moved on an idle line"); // RQ21

    property p_cfg_reset;
        $fell(reset) |-> (st_reg.row_start == `ISR_START_ZERO) && (st_reg.col_start == `ISR_START_ZERO)
            && !st_reg.row_dir && !st_reg.col_dir;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("configuration not cleared"); // RQ23
endmodule
`default_nettype wire

// File: inc/isr_params.svh
// Constants of the sensor frame readout block.
//
// Function
// RQ1: Scanning starts at twice the loaded start value, so only even starts.
// RQ2: Row and column start values each sit in a 10-bit register.
// RQ3: Column sync loads the column start, row sync loads the row start.
// RQ4: Controller may overlap or serialise integration and readout; integration end starts readout.
// RQ5: Controller sets integration from reset fall to sample rise.
// RQ6: Controller holds memory boost low around both precharge and sample.
// RQ7: Precharge ends after boost falls; pixel reset rises after boost rises.
// RQ8: Sample overlaps precharge with more than 2 us between their edges.
// RQ9: Controller raises memory boost more than 200 ns after sample rises.
// RQ10: Boost low 5 to 8.2 us, precharge 3 to 6, sample 5 to 8.
// RQ11: Integration time above 1 us, about 2 us in practice.
// RQ12: Readout starts after memory boost rises; its low time is frame overhead.
// RQ13: Controller may reset photodiodes once readout of the frame has begun.
// RQ14: Secondary slope reset lasts at least 2 us within integration.
// RQ15: Each row clock rising edge selects the next row; at the last row the code holds the address and raises frame_end.
// RQ16: Row sync dominates and reloads the row address at once, truncating frames.
// RQ17: Row sync lasts over 20 ns and holds a row clock rising edge.
// RQ18: Controller waits row overhead; column pulses over 50 ns, hold pulse 200 ns.
// RQ19: One output gives two pixels per column clock period; two outputs give one each.
// RQ20: Controller bounds window by counters: row clock ends lines, row sync ends frames.
// RQ21: Pixels are driven once column sync is high and a column clock rise occurred.
// RQ22: Controller tunes its converter sampling point for 5 to 15 ns output delay.
// RQ23: All-zero configuration starts at pixel 0,0, forward scan, one output.
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

`define ISR_ADDR_W 11
`define ISR_START_W 10
`define ISR_PIX_W 12
`define ISR_FIFO_W 25
`define ISR_FIFO_DEPTH 8
`define ISR_SYNC_W 4
`define ISR_ADDR_ZERO 11'h000
`define ISR_ADDR_LAST 11'h7ff
`define ISR_START_ZERO 10'h000
`define ISR_STEP_ONE 11'h001
`define ISR_STEP_PAIR 11'h002
`define ISR_PIX_ZERO 12'h000

`endif

// File: inc/isr_pkg.sv
// Types of the sensor frame readout block.
package isr_pkg;

    typedef enum logic [1:0] {
        ISR_LINE_IDLE = 2'b00,
        ISR_LINE_RUN = 2'b01
    } isr_line_t;

    typedef struct packed {
        logic [9:0] row_start;
        logic [9:0] col_start;
        logic row_dir;
        logic col_dir;
        logic dual_out;
        logic [10:0] row_addr;
        logic [10:0] col_addr;
        isr_line_t line;
        logic first_pend;
        logic row_clk_d;
        logic col_clk_d;
        logic row_sync_d;
        logic frame_end;
        logic overflow;
    } isr_state_t;

endpackage

// File: core/isr_sync.sv
// Two-stage synchroniser for the sensor's control pins.
`timescale 1ns/100ps
`default_nettype none
module isr_sync #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync = sync_reg;
endmodule
`default_nettype wire

// File: core/isr_fifo.sv
// Pixel FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module isr_fifo #(
    parameter int W = 25,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_reg[rd_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: tb/isr_ctl_model.sv
// Timing controller model that drives the sensor's sync and clock pins.
`timescale 1ns/100ps
`default_nettype none
module isr_ctl_model (
    input wire logic clock,
    output logic row_sync,
    output logic row_clk,
    output logic col_sync,
    output logic col_clk
);
    localparam int HALF = 4;
    logic memory_boost_ctrl;
    logic precharge_n;
    logic sample_n;
    logic pixel_reset;
    logic secondary_slope_reset;
    logic column_hold_pulse_n;
    initial begin
        row_sync = 1'b0;
        row_clk = 1'b0;
        col_sync = 1'b0;
        col_clk = 1'b0;
        memory_boost_ctrl = 1'b1;
        precharge_n = 1'b1;
        sample_n = 1'b1;
        pixel_reset = 1'b1;
        secondary_slope_reset = 1'b0;
        column_hold_pulse_n = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Row sync spans a full row clock period and holds one rising edge of it.
    task automatic frame_start();
        row_sync <= 1'b1;
        hold(HALF);
        row_clk <= 1'b1;
        pixel_reset <= 1'b1;
        hold(HALF);
        row_clk <= 1'b0;
        hold(HALF);
        row_sync <= 1'b0;
        hold(2 * HALF);
    endtask
    task automatic row_step();
        row_clk <= 1'b1;
        column_hold_pulse_n <= 1'b0;
        hold(HALF);
        row_clk <= 1'b0;
        hold(1);
        column_hold_pulse_n <= 1'b1;
        hold(2 * HALF - 1);
    endtask
    // Integration with one extra slope, then boost low around precharge and sample ends it.
    task automatic capture();
        pixel_reset <= 1'b0;
        hold(20);
        secondary_slope_reset <= 1'b1;
        hold(60);
        secondary_slope_reset <= 1'b0;
        hold(20);
        memory_boost_ctrl <= 1'b0;
        hold(5);
        precharge_n <= 1'b0;
        hold(55);
        sample_n <= 1'b0;
        hold(25);
        precharge_n <= 1'b1;
        hold(105);
        sample_n <= 1'b1;
        hold(10);
        memory_boost_ctrl <= 1'b1;
        hold(1);
    endtask
    // The column clock runs only inside a line and rests low between lines.
    task automatic line(input int n, input logic s);
        col_sync <= s;
        for (int k = 0; k < n; k++) begin
            col_clk <= 1'b1;
            hold(HALF);
            col_sync <= 1'b0;
            col_clk <= 1'b0;
            hold(HALF);
        end
        hold(2 * HALF);
    endtask
endmodule
`default_nettype wire

// File: tb/isr_readout_test.sv
// Self-checking bench of the sensor readout block.
`timescale 1ns/100ps
`default_nettype none
module isr_readout_test;
    typedef struct packed {
        logic [9:0] rs;
        logic [9:0] cs;
        logic rd;
        logic cd;
        logic dual;
        logic [3:0] n;
    } isr_case_t;
    localparam isr_case_t ROWS [4] = '{
        '{10'h001, 10'h001, 1'b0, 1'b0, 1'b0, 4'h3},
        '{10'h005, 10'h010, 1'b1, 1'b1, 1'b0, 4'h3},
        '{10'h3fe, 10'h3ff, 1'b0, 1'b0, 1'b1, 4'h4},
        '{10'h020, 10'h008, 1'b1, 1'b0, 1'b1, 4'h2}
    };
    logic clock, reset, row_sync, row_clk, col_sync, col_clk, cfg_load, out_ready;
    logic cfg_row_dir, cfg_col_dir, cfg_dual_out, seen_end;
    logic [9:0] cfg_row_start, cfg_col_start;
    logic [11:0] array_pix_a, array_pix_b, out_pix1, out_pix2;
    logic [10:0] row_sel_addr, col_sel_addr;
    logic line_active, frame_end, overflow, link_ready, out_valid, out_pix2_valid;
    logic [24:0] got [$];
    int errors, tests_run;

    isr_readout DUT (.clock(clock), .reset(reset), .row_sync(row_sync), .row_clk(row_clk),
        .col_sync(col_sync), .col_clk(col_clk), .cfg_load(cfg_load), .cfg_row_start(cfg_row_start),
        .cfg_col_start(cfg_col_start), .cfg_row_dir(cfg_row_dir), .cfg_col_dir(cfg_col_dir),
        .cfg_dual_out(cfg_dual_out), .array_pix_a(array_pix_a), .array_pix_b(array_pix_b),
        .row_sel_addr(row_sel_addr), .col_sel_addr(col_sel_addr), .line_active(line_active),
        .frame_end(frame_end), .overflow(overflow), .link_ready(link_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_pix1(out_pix1), .out_pix2(out_pix2), .out_pix2_valid(out_pix2_valid));
    isr_ctl_model ctl (.clock(clock), .row_sync(row_sync), .row_clk(row_clk), .col_sync(col_sync),
        .col_clk(col_clk));

    // Pixel array model: each pixel value encodes its own row and column.
    assign array_pix_a = {row_sel_addr[5:0], col_sel_addr[5:0]};
    assign array_pix_b = {row_sel_addr[5:0], col_sel_addr[5:0] + (cfg_col_dir ? 6'h3f : 6'h01)};

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back({out_pix2_valid, out_pix2, out_pix1});
        end
        if (frame_end === 1'b1) begin
            seen_end <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic load_cfg(input isr_case_t t);
        @(posedge clock);
        cfg_row_start <= t.rs;
        cfg_col_start <= t.cs;
        cfg_row_dir <= t.rd;
        cfg_col_dir <= t.cd;
        cfg_dual_out <= t.dual;
        cfg_load <= 1'b1;
        @(posedge clock);
        cfg_load <= 1'b0;
    endtask
    task automatic check_stream(input logic [10:0] r, input logic [10:0] c0, input logic dn, input logic dual,
            input int n);
        logic [10:0] c;
        logic [11:0] a, b;
        logic [24:0] w;
        check(got.size(), dual ? n : 2 * n);
        if (got.size() == (dual ? n : 2 * n)) begin
            for (int k = 0; k < n; k++) begin
                c = dn ? c0 - 11'(2 * k) : c0 + 11'(2 * k);
                a = {r[5:0], c[5:0]};
                b = {r[5:0], c[5:0] + (dn ? 6'h3f : 6'h01)};
                w = got.pop_front();
                if (dual) begin
                    check(w, {1'b1, b, a});
                end else begin
                    check({w[24], w[11:0]}, {1'b0, a});
                    w = got.pop_front();
                    check({w[24], w[11:0]}, {1'b0, b});
                end
            end
        end
    endtask
    task automatic run_case(input isr_case_t t);
        logic [10:0] r, c0;
        r = {t.rs, 1'b0};
        c0 = {t.cs, 1'b0};
        load_cfg(t);
        ctl.capture();
        ctl.frame_start();
        check(row_sel_addr, r);
        got.delete();
        ctl.line(t.n, 1'b1);
        check(col_sel_addr, t.cd ? 11'(c0 - 11'(2 * t.n)) : 11'(c0 + 11'(2 * t.n)));
        check(line_active, 1'b1);
        check_stream(r, c0, t.cd, t.dual, t.n);
        ctl.row_step();
        check(row_sel_addr, t.rd ? r - 11'h001 : r + 11'h001);
        check(line_active, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        finish_test();
    end
    initial begin
        reset = 1'b1;
        cfg_load = 1'b0;
        cfg_row_start = 10'h000;
        cfg_col_start = 10'h000;
        cfg_row_dir = 1'b0;
        cfg_col_dir = 1'b0;
        cfg_dual_out = 1'b0;
        out_ready = 1'b1;
        seen_end = 1'b0;
        errors = 0;
        tests_run = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        check({row_sel_addr, col_sel_addr, line_active, frame_end, overflow, out_valid}, 26'h0);
        check(link_ready, 1'b1);
        ctl.frame_start();
        got.delete();
        ctl.line(2, 1'b1);
        check_stream(11'h000, 11'h000, 1'b0, 1'b0, 2);
        foreach (ROWS[i]) begin
            run_case(ROWS[i]);
        end
        // Column clocks on an idle line must not stream or move the column.
        got.delete();
        ctl.line(2, 1'b0);
        check(got.size(), 0);
        check(col_sel_addr, 11'h014);
        // Fill the buffer with the reader stalled, then drain it.
        load_cfg('{10'h000, 10'h000, 1'b0, 1'b0, 1'b0, 4'h0});
        ctl.frame_start();
        got.delete();
        out_ready <= 1'b0;
        ctl.line(5, 1'b1);
        check({overflow, link_ready, out_valid}, 3'b101);
        out_ready <= 1'b1;
        repeat (12) @(posedge clock);
        check(got.size(), 8);
        check({link_ready, out_valid}, 2'b10);
        // Last row: the step stops there and frame sync then reloads the start.
        load_cfg('{10'h3ff, 10'h000, 1'b0, 1'b0, 1'b0, 4'h0});
        ctl.frame_start();
        check(overflow, 1'b0);
        ctl.row_step();
        check(row_sel_addr, 11'h7ff);
        seen_end <= 1'b0;
        ctl.row_step();
        check({seen_end, row_sel_addr}, 12'hfff);
        ctl.frame_start();
        check(row_sel_addr, 11'h7fe);
        // A reset in mid-run returns to the all-zero configuration.
        reset <= 1'b1;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        check({row_sel_addr, col_sel_addr, line_active, overflow}, 24'h0);
        ctl.frame_start();
        got.delete();
        ctl.line(1, 1'b1);
        check_stream(11'h000, 11'h000, 1'b0, 1'b0, 1);
        finish_test();
    end
endmodule
`default_nettype wire
